// ===== verilog/ssw_pkg.sv
// Shared widths, encodings and reset values for the synchronous memory block.
package ssw_pkg;
   localparam int ADDR_W = 6;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = LANES * LANE_W;
   localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
   localparam logic [LANES-1:0] LANES_NONE = 4'h0;
   localparam logic [LANES-1:0] LANES_ALL = 4'hf;
   typedef enum {SSW_IDLE, SSW_READ, SSW_WRITE, SSW_SLEEP} ssw_state_t;
endpackage

// ===== verilog/ssw_array.sv
// Storage array with per-lane write enables and a registered read port.
`timescale 1ns/1ps
module ssw_array #(
   parameter int ADDR_W = 6,
   parameter int LANES  = 4,
   parameter int LANE_W = 9
) (
   input  wire logic                      clock,    // System clock.
   input  wire logic [ADDR_W-1:0]         addr,     // Word address.
   input  wire logic [LANES-1:0]          lane_we,  // Lane write enables.
   input  wire logic [LANES*LANE_W-1:0]   wdata,    // Write data.
   output logic      [LANES*LANE_W-1:0]   rdata     // Read data.
);
   logic [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         always_ff @(posedge clock) begin
            if (lane_we[g]) begin
               mem[addr][g*LANE_W +: LANE_W] <= wdata[g*LANE_W +: LANE_W];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      rdata <= mem[addr];
   end
endmodule

// ===== verilog/ssw_top.sv
// Synchronous pipelined memory: select decode, writes, bus drive, sleep.
// What this block does
// [R1] The memory is selected only with primary select low, high depth select high and low depth select low.
// [R2] All lanes are written when global write is low, or when the qualifier and every lane write are low.
// [R3] After a write the data bus stays undriven until a strobe starts a new read.
// [R4] The controller deselects the memory before raising the sleep request; the block enters sleep in any cycle without a selected strobe, selected or not.
// [R5] On leaving sleep the data bus stays undriven.
// [R6] With global write high and qualifier low, only lanes whose lane write is low are written.
`timescale 1ns/1ps
module ssw_top
   import ssw_pkg::*;
#(
   parameter int AW = ssw_pkg::ADDR_W
) (
   input  wire logic                       clock,               // Clock.
   input  wire logic                       rst,                 // Sync reset.
   input  wire logic                       primary_select_n,    // Select.
   input  wire logic                       depth_select_hi,     // Depth sel.
   input  wire logic                       depth_select_lo_n,   // Depth sel.
   input  wire logic                       processor_strobe_n,  // Strobe.
   input  wire logic                       controller_strobe_n, // Strobe.
   input  wire logic                       all_lanes_write_n,   // Global wr.
   input  wire logic                       lane_write_qualifier_n, // Qual.
   input  wire logic [ssw_pkg::LANES-1:0]  lane_write_n,        // Lane wr.
   input  wire logic                       sleep_request,       // Sleep pin.
   input  wire logic                       output_enable_n,     // Async OE.
   input  wire logic [AW-1:0]              addr,                // Address.
   input  wire logic [ssw_pkg::DATA_W-1:0] dq_in,               // Bus in.
   output logic      [ssw_pkg::DATA_W-1:0] dq_out,              // Bus out.
   output logic                            dq_oe,               // Bus drive.
   output logic                            asleep               // In sleep.
);
   import ssw_pkg::*;

   // Two-stage synchronisers for the asynchronous pins.
   // Only the second stage of each pair is read by the control logic, so a
   // metastable first stage never reaches the state machine.
   // The output enable resets to its deasserted level so that the bus is
   // never driven before the pin has been seen twice.
   logic sleep_s1_reg, sleep_s1_next;
   logic sleep_s2_reg, sleep_s2_next;
   logic oe_s1_reg,    oe_s1_next;
   logic oe_s2_reg,    oe_s2_next;

   always_comb begin
      sleep_s1_next = sleep_request;
      sleep_s2_next = sleep_s1_reg;
      oe_s1_next    = output_enable_n;
      oe_s2_next    = oe_s1_reg;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sleep_s1_reg <= 1'b0;
         sleep_s2_reg <= 1'b0;
         oe_s1_reg    <= 1'b1;
         oe_s2_reg    <= 1'b1;
      end else begin
         sleep_s1_reg <= sleep_s1_next;
         sleep_s2_reg <= sleep_s2_next;
         oe_s1_reg    <= oe_s1_next;
         oe_s2_reg    <= oe_s2_next;
      end
   end

   // Turns the three write inputs into one enable per byte lane.
   // Global write overrides the qualifier; with both inactive no lane is
   // written, which makes the access a read.
   function automatic logic [LANES-1:0] lane_mask(
      input logic            gw_n,
      input logic            qual_n,
      input logic [LANES-1:0] bw_n
   );
      if (!gw_n) begin
         lane_mask = LANES_ALL; // [R2]
      end else if (!qual_n) begin
         lane_mask = ~bw_n; // [R6]
      end else begin
         lane_mask = LANES_NONE;
      end
   endfunction

   ssw_state_t        state_reg, state_next;
   logic [AW-1:0]     addr_reg, addr_next;
   logic              oe_reg, oe_next;
   logic              asleep_reg, asleep_next;
   logic [LANES-1:0]  lane_we;
   logic              selected;
   logic              strobe;
   logic [DATA_W-1:0] rdata;

   // Deselection by any one enable at its inactive level.
   assign selected = !primary_select_n && depth_select_hi
                     && !depth_select_lo_n; // [R1]
   assign strobe = !processor_strobe_n || !controller_strobe_n;

   // Access control. A selected strobe starts a new access and latches the
   // address; later strobe-free cycles continue it at the latched address.
   // The bus is only ever turned on by a read started with a strobe, so a
   // write or a wake-up always leaves it undriven until the next read.
   // A strobe seen while deselected ends any access and frees the bus.

   always_comb begin
      state_next  = state_reg;
      addr_next   = addr_reg;
      oe_next     = oe_reg;
      asleep_next = asleep_reg;
      lane_we     = LANES_NONE;
      case (state_reg)
         SSW_SLEEP: begin
            oe_next = 1'b0;
            if (!sleep_s2_reg) begin
               state_next  = SSW_IDLE;
               asleep_next = 1'b0;
               oe_next     = 1'b0; // [R5]
            end
         end
         default: begin
            // Sleep is honoured in any cycle without a selected strobe.
            if (sleep_s2_reg && !(strobe && selected)) begin // [R4]
               state_next  = SSW_SLEEP;
               asleep_next = 1'b1;
               oe_next     = 1'b0;
            end else if (strobe && selected) begin
               addr_next = addr;
               // A processor strobe always starts a read; the write
               // inputs are looked at on the following cycle.
               if (!processor_strobe_n) begin
                  state_next = SSW_READ;
                  oe_next    = !oe_s2_reg; // [R3]
               end else if (|lane_mask(all_lanes_write_n,
                                      lane_write_qualifier_n,
                                      lane_write_n)) begin
                  state_next = SSW_WRITE;
                  oe_next    = 1'b0; // [R3]
                  lane_we    = lane_mask(all_lanes_write_n,
                                         lane_write_qualifier_n,
                                         lane_write_n);
               end else begin
                  state_next = SSW_READ;
                  oe_next    = !oe_s2_reg; // [R3]
               end
            end else if (strobe) begin
               state_next = SSW_IDLE;
               oe_next    = 1'b0;
            end else if (state_reg == SSW_READ) begin
               // Write inputs following a processor strobe turn the
               // access into a write of the latched address.
               lane_we = lane_mask(all_lanes_write_n,
                                   lane_write_qualifier_n,
                                   lane_write_n);
               if (|lane_we) begin
                  state_next = SSW_WRITE;
                  oe_next    = 1'b0; // [R3]
               end else begin
                  oe_next = !oe_s2_reg;
               end
            end else if (state_reg == SSW_WRITE) begin
               lane_we = lane_mask(all_lanes_write_n,
                                   lane_write_qualifier_n,
                                   lane_write_n);
               oe_next = 1'b0; // [R3]
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg  <= SSW_IDLE;
         addr_reg   <= '0;
         oe_reg     <= 1'b0;
         asleep_reg <= 1'b0;
      end else begin
         state_reg  <= state_next;
         addr_reg   <= addr_next;
         oe_reg     <= oe_next;
         asleep_reg <= asleep_next;
      end
   end

   // The array sees the new address in the strobe cycle itself, so that a
   // read is ready one cycle later and a controller write lands at once.
   logic [AW-1:0] array_addr;
   assign array_addr = (strobe && selected) ? addr : addr_reg;

   ssw_array #(
      .ADDR_W (AW),
      .LANES  (LANES),
      .LANE_W (LANE_W)
   ) u_array (
      .clock   (clock),
      .addr    (array_addr),
      .lane_we (lane_we),
      .wdata   (dq_in),
      .rdata   (rdata)
   );

   // Output stage. Every output leaves from a flip-flop so that the pins
   // never glitch with the decode logic behind them.
   logic [DATA_W-1:0] dq_out_next;
   logic              dq_oe_next;
   logic              asleep_out_next;

   always_comb begin
      dq_out_next     = rdata;
      dq_oe_next      = oe_reg;
      asleep_out_next = asleep_reg;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         dq_out <= DATA_RST;
         dq_oe  <= 1'b0;
         asleep <= 1'b0;
      end else begin
         dq_out <= dq_out_next;
         dq_oe  <= dq_oe_next;
         asleep <= asleep_out_next;
      end
   end
endmodule

// ===== verif/ssw_properties.sv
// Checker for select, bus drive and sleep behaviour.
`timescale 1ns/1ps
module ssw_props (
   input wire logic clock, // Clock.
   input wire logic rst, // Reset.
   input wire logic primary_select_n, // Select.
   input wire logic depth_select_hi, // Select.
   input wire logic depth_select_lo_n, // Select.
   input wire logic processor_strobe_n, // Strobe.
   input wire logic controller_strobe_n, // Strobe.
   input wire logic all_lanes_write_n, // Write.
   input wire logic lane_write_qualifier_n, // Qualifier.
   input wire logic sleep_request, // Sleep.
   input wire logic dq_oe, // Drive.
   input wire logic asleep // Asleep.
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire sel = !primary_select_n && depth_select_hi && !depth_select_lo_n;
   wire stb = !processor_strobe_n || !controller_strobe_n;
   wire cs = !controller_strobe_n;
   property p_sel_read;
      cs && sel && all_lanes_write_n && lane_write_qualifier_n
      && !sleep_request && !asleep |-> ##[1:3] dq_oe;
   endproperty
   a_sel_read: assert property (p_sel_read) else $error("no drive");
   property p_desel;
      cs && !sel |=> ##[0:2] !dq_oe;
   endproperty
   a_desel: assert property (p_desel) else $error("drive kept");
   property p_wr_hiz;
      cs && sel && !all_lanes_write_n |-> ##2 !dq_oe;
   endproperty
   a_wr_hiz: assert property (p_wr_hiz) else $error("drive on write");
   property p_rd_cause;
      $rose(dq_oe) |-> $past(stb, 2) || $past(stb, 3);
   endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("no strobe");
   property p_wake_hiz;
      $fell(asleep) |-> !dq_oe [*2];
   endproperty
   a_wake_hiz: assert property (p_wake_hiz) else $error("drive on wake");
   c_read: cover property (cs && sel);
   c_desel: cover property (cs && !sel);
   c_wake: cover property ($fell(asleep));
endmodule

bind ssw_top ssw_props chk_u (.*);

// ===== verif/ssw_host.sv
// Processor and controller model that drives the memory pins.
`timescale 1ns/1ps
module ssw_host
   import ssw_pkg::*;
(
   input wire logic clock, // Clock.
   output logic primary_select_n, // Pin.
   output logic depth_select_hi, // Pin.
   output logic depth_select_lo_n, // Pin.
   output logic processor_strobe_n, // Pin.
   output logic controller_strobe_n, // Pin.
   output logic all_lanes_write_n, // Pin.
   output logic lane_write_qualifier_n, // Pin.
   output logic [ssw_pkg::LANES-1:0] lane_write_n, // Pin.
   output logic sleep_request, // Pin.
   output logic [ssw_pkg::ADDR_W-1:0] addr, // Pin.
   output logic [ssw_pkg::DATA_W-1:0] dq_in // Pin.
);
   initial begin
      {primary_select_n, depth_select_hi, depth_select_lo_n} = '1;
      {processor_strobe_n, controller_strobe_n, all_lanes_write_n} = '1;
      {lane_write_qualifier_n, lane_write_n} = '1;
      sleep_request = 1'b0;
      addr = '0;
      dq_in = '0;
   end
   task automatic cyc(input logic [LANES+6:0] c, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      @(posedge clock);
      {primary_select_n, depth_select_hi, depth_select_lo_n, processor_strobe_n,
       controller_strobe_n, all_lanes_write_n, lane_write_qualifier_n,
       lane_write_n} <= c;
      addr <= a;
      dq_in <= d;
      @(posedge clock);
      {processor_strobe_n, controller_strobe_n, all_lanes_write_n,
       lane_write_qualifier_n, lane_write_n} <= '1;
      dq_in <= ~d;
   endtask
   task automatic doze(input logic on);
      @(posedge clock);
      primary_select_n <= 1'b1;
      @(posedge clock);
      sleep_request <= on;
   endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the synchronous memory block.
`timescale 1ns/1ps
module testbench;
   import ssw_pkg::*;
   logic clock = 1'b0, rst = 1'b1, output_enable_n = 1'b0;
   logic primary_select_n, depth_select_hi, depth_select_lo_n;
   logic processor_strobe_n, controller_strobe_n, all_lanes_write_n;
   logic lane_write_qualifier_n, sleep_request, dq_oe, asleep;
   logic [LANES-1:0] lane_write_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] dq_in, dq_out;
   int err_count = 0, check_count = 0;
   always #5 clock = ~clock;
   ssw_top dut_u (.*);
   ssw_host host_u (.*);
   task automatic check(input string n, input logic [DATA_W-1:0] s, e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [LANES+1:0] w, input logic [2:0] s,
                     input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic eoe);
      host_u.cyc({s, 2'h2, w}, a, d);
      repeat (2) @(posedge clock);
      #1;
      check("drive after write", DATA_W'(dq_oe), DATA_W'(eoe));
   endtask
   task automatic rd(input logic p, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] e);
      host_u.cyc({3'h2, ~p, p, 2'h3, LANES_ALL}, a, '0);
      repeat (2) @(posedge clock);
      #1;
      check("drive on read", DATA_W'(dq_oe), 36'h1);
      check("read data", dq_out, e);
   endtask
   task automatic t_full;
      wr(6'h1f, 3'h2, 6'h01, 36'h123456789, 1'b0);
      wr(6'h20, 3'h2, 6'h02, 36'h9abcdef01, 1'b0);
      rd(1'b0, 6'h01, 36'h123456789);
      rd(1'b1, 6'h02, 36'h9abcdef01);
      $display("full-width test done");
   endtask
   task automatic t_lanes;
      logic [DATA_W-1:0] e;
      for (int i = 0; i < LANES; i++) begin
         wr(6'h1f, 3'h2, 6'h03, '0, 1'b0);
         e = '0;
         e[i*LANE_W +: LANE_W] = '1;
         wr({2'h2, ~(4'h1 << i)}, 3'h2, 6'h03, '1, 1'b0);
         rd(1'b0, 6'h03, e);
      end
      // Neither global write nor qualifier active: a read, nothing written.
      wr(6'h30, 3'h2, 6'h03, '0, 1'b1);
      rd(1'b1, 6'h03, e);
      $display("lane test done");
   endtask
   task automatic t_select;
      logic [2:0] s [3] = '{3'h6, 3'h0, 3'h3};
      wr(6'h1f, 3'h2, 6'h04, 36'h5a5a5a5a5, 1'b0);
      foreach (s[i]) wr(6'h1f, s[i], 6'h04, '0, 1'b0);
      rd(1'b0, 6'h04, 36'h5a5a5a5a5);
      $display("select test done");
   endtask
   task automatic t_sleep;
      host_u.doze(1'b1);
      repeat (6) @(posedge clock);
      #1;
      check("asleep", DATA_W'({asleep, dq_oe}), 36'h2);
      host_u.doze(1'b0);
      repeat (6) @(posedge clock);
      #1;
      check("awake", DATA_W'({asleep, dq_oe}), 36'h0);
      rd(1'b1, 6'h04, 36'h5a5a5a5a5);
      $display("sleep test done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      t_full;
      t_lanes;
      t_select;
      t_sleep;
      results;
   end
endmodule
